//--- commutation_core.v
// Purpose: rotor sensor commutation with safe direction reversal
// Assumes: sensor, direction and comparator inputs are asynchronous pins
// Notes: analog comparators are seen only as their logic results
// Notes: drives are registered, so a pin change shows three edges later, a comparator trip or period start four
// Functional notes
// - sensors and registered direction decode into upper and lower drives.
// - direction passes a latch then a two-bit register before decoding.
// - the latch is transparent while slow rotation is indicated.
// - the latch holds its value while rotation is not slow.
// - all drives are off while latch or register stages disagree.
// - the register advances on the oscillator so a change lands in one to two periods.
// - every direction request toggle starts or restarts the tachometer pulse.
// - a comparator trip clears the chop latch and forces the chop off state.
// - the comparator result (error output above ramp) is the chop request.
// - overcurrent commands soft start and holds drives off while present.
`include "commutation_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module commutation_core
#(
    parameter TACH_CYCLES = `TACH_PULSE_CYCLES
)
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // rotor sensors
    input wire rotor_sensor_a,
    input wire rotor_sensor_b,
    input wire rotor_sensor_c,
    // direction and speed
    input wire dir_req,
    input wire speed_below_threshold,
    // pwm and protection
    input wire osc_period_start,
    input wire pwm_comparator_trip,
    input wire overcurrent,
    // outputs
    output reg [2:0] upper_switch_drive,
    output reg [2:0] lower_switch_drive,
    output reg rotation_pulse_output,
    output reg soft_start_cmd
);
    reg [7:0] s1_q;
    reg [7:0] s2_q;
    reg [2:0] ready_q;
    reg osc_prev_q;
    reg dir_prev_q;
    reg chop_q;
    reg [15:0] tach_cnt_q;
    wire sync_dir;
    wire sync_slow;
    wire sync_osc;
    wire sync_trip;
    wire sync_fault;
    wire dir_decoded;
    wire dir_mismatch;
    wire osc_tick;
    wire dir_toggle;
    wire blank_all;
    wire chop_off;
    wire [2:0] code;
    wire [2:0] up_dec;
    wire [2:0] lo_dec;
    reg [2:0] up_d;
    reg [2:0] lo_d;
    // two-flop sync of all pin inputs
    // sync word, low to high: sensors a b c, direction, slow, oscillator, trip, fault
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end
        else
        begin
            s1_q <= {overcurrent, pwm_comparator_trip, osc_period_start, speed_below_threshold,
                dir_req, rotor_sensor_c, rotor_sensor_b, rotor_sensor_a};
            s2_q <= s1_q;
        end
    end
    // edge detectors trust history only once sync and previous-value flops
    // hold real pin levels, otherwise a pin high at reset fakes an edge
    always @(posedge core_clk)
    begin
        if (!rst_n)
            ready_q <= 3'h0;
        else
            ready_q <= {ready_q[1:0], 1'b1};
    end
    assign code = s2_q[`SYNC_C_BIT:`SYNC_A_BIT];
    assign sync_dir = s2_q[`SYNC_DIR_BIT];
    assign sync_slow = s2_q[`SYNC_SLOW_BIT];
    assign sync_osc = s2_q[`SYNC_OSC_BIT];
    assign sync_trip = s2_q[`SYNC_TRIP_BIT];
    assign sync_fault = s2_q[`SYNC_FAULT_BIT];
    assign osc_tick = ready_q[2] && sync_osc && !osc_prev_q;
    assign dir_toggle = ready_q[2] && (sync_dir != dir_prev_q);
    direction_path u_dir
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .dir_req(sync_dir),
        .slow_rotation(sync_slow),
        .osc_tick(osc_tick),
        .dir_decoded(dir_decoded),
        .dir_mismatch(dir_mismatch)
    );
    function [5:0] decode;
        input [2:0] c;
        input d;
        begin
            case (c)
                3'h1: decode = d ? {3'h2, 3'h1} : {3'h1, 3'h2};
                3'h3: decode = d ? {3'h4, 3'h1} : {3'h1, 3'h4};
                3'h2: decode = d ? {3'h4, 3'h2} : {3'h2, 3'h4};
                3'h6: decode = d ? {3'h1, 3'h2} : {3'h2, 3'h1};
                3'h4: decode = d ? {3'h1, 3'h4} : {3'h4, 3'h1};
                3'h5: decode = d ? {3'h2, 3'h4} : {3'h4, 3'h2};
                default: decode = {`DRIVE_OFF, `DRIVE_OFF};
            endcase
        end
    endfunction
    // previous levels for the edge detectors
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            osc_prev_q <= 1'b0;
            dir_prev_q <= 1'b0;
        end
        else
        begin
            osc_prev_q <= sync_osc;
            dir_prev_q <= sync_dir;
        end
    end
    // set at period start
    // trip dominance keeps a tripped cycle chopped to its end
    always @(posedge core_clk)
    begin
        if (!rst_n)
            chop_q <= 1'b0;
        else if (sync_trip)
            chop_q <= 1'b0;
        else if (osc_tick)
            chop_q <= 1'b1;
    end
    // pulse on direction toggle
    // a toggle inside a running pulse restarts its width
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            tach_cnt_q <= 16'h0000;
            rotation_pulse_output <= 1'b0;
        end
        else if (dir_toggle)
        begin
            tach_cnt_q <= TACH_CYCLES[15:0];
            rotation_pulse_output <= 1'b1;
        end
        else if (tach_cnt_q > 16'h0001)
        begin
            tach_cnt_q <= tach_cnt_q - 16'h0001;
        end
        else
        begin
            tach_cnt_q <= 16'h0000;
            rotation_pulse_output <= 1'b0;
        end
    end
    always @(posedge core_clk)
    begin
        if (!rst_n)
            soft_start_cmd <= 1'b0;
        else
            soft_start_cmd <= sync_fault;
    end
    // registered drives keep decode glitches off the switch pins
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            upper_switch_drive <= `DRIVE_OFF;
            lower_switch_drive <= `DRIVE_OFF;
        end
        else
        begin
            upper_switch_drive <= up_d;
            lower_switch_drive <= lo_d;
        end
    end
    assign {up_dec, lo_dec} = decode(code, dir_decoded);
    assign blank_all = dir_mismatch || sync_fault;
    assign chop_off = !chop_q;
    always @*
    begin
        up_d = up_dec;
        lo_d = lo_dec;
        if (blank_all)
        begin
            up_d = `DRIVE_OFF;
            lo_d = `DRIVE_OFF;
        end
        else if (chop_off)
        begin
            up_d = `DRIVE_OFF;
        end
    end
endmodule // commutation_core
`default_nettype wire

//--- commutation_defs.vh
// Purpose: shared constants for the commutation core
// Assumes: 100 MHz core_clk
// Notes: sensor code order is {c, b, a}
`ifndef COMMUTATION_DEFS_VH
`define COMMUTATION_DEFS_VH
`define CORE_CLK_MHZ 100
`define TACH_PULSE_NS 1000
`define TACH_PULSE_CYCLES ((`TACH_PULSE_NS * `CORE_CLK_MHZ) / 1000)
`define DRIVE_OFF 3'h0
`define UPPER_IDX 0
`define LOWER_IDX 3
`define SYNC_A_BIT 0
`define SYNC_C_BIT 2
`define SYNC_DIR_BIT 3
`define SYNC_SLOW_BIT 4
`define SYNC_OSC_BIT 5
`define SYNC_TRIP_BIT 6
`define SYNC_FAULT_BIT 7
`endif

//--- direction_path.v
// Purpose: direction latch and two-stage direction register
// Assumes: osc_tick is a one-cycle pulse on core_clk
// Notes: reports a mismatch while any stage is still settling
`timescale 1ns/1ps
`default_nettype none
module direction_path
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // controls
    input wire dir_req,
    input wire slow_rotation,
    input wire osc_tick,
    // results
    output wire dir_decoded,
    output wire dir_mismatch
);
    reg latch_q;
    reg [1:0] shift_q;
    always @(posedge core_clk)
    begin
        if (!rst_n)
            latch_q <= 1'b0;
        else if (slow_rotation)
            latch_q <= dir_req;
    end
    always @(posedge core_clk)
    begin
        if (!rst_n)
            shift_q <= 2'h0;
        else if (osc_tick)
            shift_q <= {shift_q[0], latch_q};
    end
    assign dir_decoded = shift_q[1];
    assign dir_mismatch = (slow_rotation && (dir_req != latch_q)) || (latch_q != shift_q[0])
        || (shift_q[0] != shift_q[1]);
endmodule // direction_path
`default_nettype wire

//--- rotor_model.sv
// Purpose: rotor sensor source
// Assumes: pos moves one step at a time
// Notes: bad forces the all-low code
`timescale 1ns/1ps
`default_nettype none
module rotor_model
(
    // control
    input wire logic [2:0] pos,
    input wire logic bad,
    // sensors
    output logic rotor_sensor_a,
    output logic rotor_sensor_b,
    output logic rotor_sensor_c
);
    localparam logic [17:0] SEQ = 18'h2cc99;
    assign {rotor_sensor_c, rotor_sensor_b, rotor_sensor_a} = bad ? 3'h0 : SEQ[pos * 3 +: 3];
endmodule // rotor_model
`default_nettype wire

//--- commutation_props.sv
// Purpose: port checker for commutation_core
// Assumes: pins pass two sync flops
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module commutation_props
#(
    parameter TACH_CYCLES = 4
)
(
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // pins
    input wire rotor_sensor_a,
    input wire rotor_sensor_b,
    input wire rotor_sensor_c,
    input wire dir_req,
    input wire speed_below_threshold,
    input wire pwm_comparator_trip,
    input wire overcurrent,
    // outputs
    input wire [2:0] upper_switch_drive,
    input wire [2:0] lower_switch_drive,
    input wire rotation_pulse_output,
    input wire soft_start_cmd
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [2:0] code = {rotor_sensor_c, rotor_sensor_b, rotor_sensor_a};
    wire off = (upper_switch_drive | lower_switch_drive) == 3'h0;
    // three edges: two sync flops plus the output stage
    a_drive_one_hot: assert property ($onehot0(upper_switch_drive) && $onehot0(lower_switch_drive))
        else $error("drive not one-hot");
    a_no_overlap: assert property ((upper_switch_drive & lower_switch_drive) == 3'h0) else $error("overlap");
    a_invalid_off: assert property ((code == 3'h0 || code == 3'h7)[*4] |-> off) else $error("bad code");
    a_fault_off: assert property (overcurrent[*4] |-> off && soft_start_cmd) else $error("fault drive");
    a_fault_clear: assert property (!overcurrent[*4] |-> !soft_start_cmd) else $error("stray soft");
    // trip has one more stage: the chop latch sits before the drive flops
    a_trip_chop: assert property (pwm_comparator_trip[*5] |-> upper_switch_drive == 3'h0)
        else $error("upper while chopped");
    a_dir_pulse: assert property ($changed(dir_req) |-> ##[1:4] rotation_pulse_output) else $error("no pulse");
    a_reverse_blank: assert property (speed_below_threshold[*4] ##0 $changed(dir_req) |-> ##[1:5] off)
        else $error("no blanking");
    c_reversal: cover property (speed_below_threshold ##0 $changed(dir_req));
    c_fault: cover property ($rose(soft_start_cmd));
    c_drive: cover property (upper_switch_drive != 3'h0);
endmodule // commutation_props
bind commutation_core commutation_props #(.TACH_CYCLES(TACH_CYCLES)) u_props (.*);
`default_nettype wire

//--- test_safe_direction_reversal_commutation.sv
// Purpose: self-checking bench for commutation_core
// Assumes: oscillator period of 8 clocks
// Notes: short tach pulse keeps the run brief
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) tests_run++; \
    if ((v) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, v); end
module test_safe_direction_reversal_commutation;
    logic core_clk = 0, rst_n = 0, dir_req = 0, speed_below_threshold = 1, bad = 0;
    logic osc_period_start = 0, pwm_comparator_trip = 0, overcurrent = 0;
    logic rotor_sensor_a, rotor_sensor_b, rotor_sensor_c, rotation_pulse_output, soft_start_cmd;
    logic [2:0] pos = 0, upper_switch_drive, lower_switch_drive;
    int fails = 0, tests_run = 0;
    // rows: position, upper, lower
    logic [8:0] rows [6] = '{9'h00a, 9'h04c, 9'h094, 9'h0d1, 9'h121, 9'h162};
    wire [5:0] drv = {upper_switch_drive, lower_switch_drive};
    rotor_model model (.*);
    commutation_core #(.TACH_CYCLES(4)) dut (.*);
    initial forever #5 core_clk = ~core_clk;
    initial #6 forever #40 osc_period_start = ~osc_period_start;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #20000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        cyc(2);
        `CHK("reset", 6'h00, drv)
        rst_n = 1;
        foreach (rows[i])
        begin
            pos = rows[i][8:6];
            cyc(20);
            `CHK("decode", rows[i][5:0], drv)
        end
        dir_req = 1;
        cyc(4);
        `CHK("pulse", 1'b1, rotation_pulse_output)
        cyc(1);
        `CHK("blank", 6'h00, drv)
        cyc(30);
        `CHK("reversed", 6'h14, drv)
        `CHK("pulse end", 1'b0, rotation_pulse_output)
        // fast rotation: request must be ignored
        speed_below_threshold = 0;
        cyc(5);
        dir_req = 0;
        cyc(4);
        `CHK("fast pulse", 1'b1, rotation_pulse_output)
        cyc(30);
        `CHK("held", 6'h14, drv)
        pwm_comparator_trip = 1;
        cyc(20);
        `CHK("chopped", 6'h04, drv)
        pwm_comparator_trip = 0;
        cyc(20);
        `CHK("rearmed", 6'h14, drv)
        overcurrent = 1;
        cyc(5);
        `CHK("fault", 7'h40, {soft_start_cmd, drv})
        overcurrent = 0;
        cyc(20);
        `CHK("recover", 7'h14, {soft_start_cmd, drv})
        bad = 1;
        cyc(5);
        `CHK("invalid", 6'h00, drv)
        // mid-run reset: direction path returns to its reset sense
        bad = 0;
        rst_n = 0;
        cyc(2);
        `CHK("mid reset", 8'h00, {rotation_pulse_output, soft_start_cmd, drv})
        rst_n = 1;
        cyc(20);
        `CHK("after reset", 6'h22, drv)
        tally_and_finish();
    end
endmodule // test_safe_direction_reversal_commutation
`default_nettype wire
